/* shared/bsf_pkg.sv */
// Overview of operation
// - I/O bit clear, two cycles, forces bit zero
// - Shift left, zero into bit 0
// - Shift right, zero into bit 7
// - Rotate left through carry
// - Rotate right through carry
// - Arithmetic right shift keeps sign bit
// - Swap register nibbles in one cycle
// - Set or clear status flag selected by field
// - Copy register bit b into transfer flag
// - Copy transfer flag into register bit b
// - Carry flag set and clear
// - Negative flag set and clear
// - Zero flag set and clear
// - Global interrupt enable set and clear
// - Signed test flag set and clear
// - Overflow flag set and clear
// - Transfer flag set and clear
// - Half-carry flag set and clear
// - Shifts update zero, carry, negative, overflow
package bsf_pkg;

    // ----------------------------------------------------------------
    // Widths and bit positions
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int BIT_SEL_W = 3;
    localparam int IO_ADDR_W = 5;
    localparam int MSB = 7;
    localparam int NIB_W = 4;
    localparam logic [7:0] LSB_ONE = 8'h01;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // Status flag positions and reset value
    // ----------------------------------------------------------------
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // ----------------------------------------------------------------
    // Operations and sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        BSF_OP_NONE,
        BSF_OP_IO_CLR,
        BSF_OP_LSL,
        BSF_OP_LSR,
        BSF_OP_ROL,
        BSF_OP_ROR,
        BSF_OP_ASR,
        BSF_OP_SWAP,
        BSF_OP_FSET,
        BSF_OP_FCLR,
        BSF_OP_TSTORE,
        BSF_OP_TLOAD
    } bsf_op_t;

    typedef enum logic {
        BSF_ST_IDLE,
        BSF_ST_IO_WR
    } bsf_state_t;

endpackage

/* hw/bsf_shift_unit.sv */
`timescale 1ns/1ns
module bsf_shift_unit
    import bsf_pkg::*;
(
    input wire bsf_op_t op,
    input wire logic [7:0] din,
    input wire logic cin,
    output logic [7:0] dout,
    output logic cout,
    output logic is_shift
);

    // ----------------------------------------------------------------
    // Shift, rotate and swap datapath
    // ----------------------------------------------------------------
    always_comb
    begin
        dout = din;
        cout = cin;
        is_shift = 1'b1;
        unique case (op)
            BSF_OP_LSL:
            begin
                dout = {din[MSB-1:0], 1'b0};
                cout = din[MSB];
            end
            BSF_OP_LSR:
            begin
                dout = {1'b0, din[MSB:1]};
                cout = din[0];
            end
            BSF_OP_ROL:
            begin
                dout = {din[MSB-1:0], cin};
                cout = din[MSB];
            end
            BSF_OP_ROR:
            begin
                dout = {cin, din[MSB:1]};
                cout = din[0];
            end
            BSF_OP_ASR:
            begin
                dout = {din[MSB], din[MSB:1]};
                cout = din[0];
            end
            BSF_OP_SWAP:
            begin
                dout = {din[NIB_W-1:0], din[MSB:NIB_W]};
                is_shift = 1'b0;
            end
            default:
            begin
                is_shift = 1'b0;
            end
        endcase
    end

endmodule

/* hw/bsf_core.sv */
`timescale 1ns/1ns
module bsf_core
    import bsf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic op_valid,
    input wire bsf_op_t op_code,
    input wire logic [BIT_SEL_W-1:0] op_bit,
    input wire logic [BIT_SEL_W-1:0] op_flag_sel,
    input wire logic [IO_ADDR_W-1:0] op_io_addr,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] io_data,
    output logic [7:0] rd_result_q,
    output logic rd_wr_q,
    output logic io_rd_q,
    output logic io_wr_q,
    output logic [IO_ADDR_W-1:0] io_addr_q,
    output logic [7:0] io_wdata_q,
    output logic [7:0] status_q,
    output logic busy_q,
    output logic done_q
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    bsf_state_t state_q;
    bsf_state_t state_d;
    logic [BIT_SEL_W-1:0] io_bit_q;
    logic [7:0] sh_out;
    logic sh_cout;
    logic sh_is;

    // An operation is taken only when idle and enabled
    wire accept = op_valid && clk_en && (state_q == BSF_ST_IDLE);
    wire acc_io = accept && (op_code == BSF_OP_IO_CLR);
    wire acc_sh = accept && sh_is;
    wire acc_swap = accept && (op_code == BSF_OP_SWAP);
    wire acc_fset = accept && (op_code == BSF_OP_FSET);
    wire acc_fclr = accept && (op_code == BSF_OP_FCLR);
    wire acc_tst = accept && (op_code == BSF_OP_TSTORE);
    wire acc_tld = accept && (op_code == BSF_OP_TLOAD);
    wire io_phase2 = clk_en && (state_q == BSF_ST_IO_WR);
    wire [7:0] flag_mask = LSB_ONE << op_flag_sel;
    wire [7:0] bit_mask = LSB_ONE << op_bit;
    wire [7:0] io_clr_mask = ~(LSB_ONE << io_bit_q);
    wire [7:0] tld_val = status_q[FLAG_T] ? (rd_data | bit_mask) : (rd_data & ~bit_mask);
    wire sh_zero = (sh_out == DATA_ZERO);
    wire sh_neg = sh_out[MSB];

    bsf_shift_unit u_shift (
        .op(op_code),
        .din(rd_data),
        .cin(status_q[FLAG_C]),
        .dout(sh_out),
        .cout(sh_cout),
        .is_shift(sh_is)
    );

    // ----------------------------------------------------------------
    // Next status value
    // ----------------------------------------------------------------
    logic [7:0] status_d;
    always_comb
    begin
        status_d = status_q;
        if (acc_sh)
        begin
            status_d[FLAG_C] = sh_cout;
            status_d[FLAG_Z] = sh_zero;
            status_d[FLAG_N] = sh_neg;
            status_d[FLAG_V] = sh_neg ^ sh_cout;
        end
        else if (acc_fset)
            status_d = status_q | flag_mask;
        else if (acc_fclr)
            status_d = status_q & ~flag_mask;
        else if (acc_tst)
            status_d[FLAG_T] = rd_data[op_bit];
    end

    // Sequencer for the two-cycle I/O read-modify-write
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            BSF_ST_IDLE:
                if (acc_io)
                    state_d = BSF_ST_IO_WR;
            BSF_ST_IO_WR:
                if (clk_en)
                    state_d = BSF_ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Sequencer and status flags
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_q <= BSF_ST_IDLE;
            status_q <= STATUS_RST;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            status_q <= status_d;
        end
    end

    // Register file write-back
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rd_wr_q <= 1'b0;
            rd_result_q <= DATA_ZERO;
        end
        else if (clk_en)
        begin
            rd_wr_q <= acc_sh || acc_swap || acc_tld;
            if (acc_sh || acc_swap)
                rd_result_q <= sh_out;
            else if (acc_tld)
                rd_result_q <= tld_val;
        end
    end

    // I/O read then write of the addressed location
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            io_rd_q <= 1'b0;
            io_wr_q <= 1'b0;
            io_addr_q <= '0;
            io_wdata_q <= DATA_ZERO;
            io_bit_q <= '0;
        end
        else if (clk_en)
        begin
            io_rd_q <= acc_io;
            io_wr_q <= io_phase2;
            if (acc_io)
            begin
                io_addr_q <= op_io_addr;
                io_bit_q <= op_bit;
            end
            if (io_phase2)
                io_wdata_q <= io_data & io_clr_mask;
        end
    end

    // Busy and completion strobes
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (clk_en)
        begin
            busy_q <= acc_io;
            done_q <= (accept && !acc_io && (op_code != BSF_OP_NONE)) || io_phase2;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    io_clr_seq_a: assert property (acc_io ##1 clk_en |=> io_wr_q && done_q && !busy_q)
        else $error("io clear did not finish in two cycles");
    io_clr_bit_a: assert property (io_wr_q |-> io_wdata_q[io_bit_q] == 1'b0)
        else $error("io clear left bit set");
    lsl_data_a: assert property (accept && op_code == BSF_OP_LSL |=>
        rd_result_q == {$past(rd_data[MSB-1:0]), 1'b0} && status_q[FLAG_C] == $past(rd_data[MSB]))
        else $error("shift left wrong");
    lsr_data_a: assert property (accept && op_code == BSF_OP_LSR |=>
        rd_result_q == {1'b0, $past(rd_data[MSB:1])} && !status_q[FLAG_N])
        else $error("shift right wrong");
    rol_carry_a: assert property (accept && op_code == BSF_OP_ROL |=>
        rd_result_q[0] == $past(status_q[FLAG_C]) && status_q[FLAG_C] == $past(rd_data[MSB]))
        else $error("rotate left wrong");
    ror_carry_a: assert property (accept && op_code == BSF_OP_ROR |=>
        rd_result_q[MSB] == $past(status_q[FLAG_C]) && status_q[FLAG_C] == $past(rd_data[0]))
        else $error("rotate right wrong");
    asr_sign_a: assert property (accept && op_code == BSF_OP_ASR |=>
        rd_result_q == {$past(rd_data[MSB]), $past(rd_data[MSB:1])})
        else $error("arith shift wrong");
    swap_nib_a: assert property (accept && op_code == BSF_OP_SWAP |=>
        rd_result_q == {$past(rd_data[NIB_W-1:0]), $past(rd_data[MSB:NIB_W])} && rd_wr_q)
        else $error("swap wrong");
    flag_set_a: assert property (acc_fset |=> status_q == ($past(status_q) | $past(flag_mask)))
        else $error("flag set wrong");
    flag_clr_a: assert property (acc_fclr |=> status_q == ($past(status_q) & ~$past(flag_mask)))
        else $error("flag clear wrong");
    t_store_a: assert property (acc_tst |=> status_q[FLAG_T] == $past(rd_data[op_bit]))
        else $error("transfer store wrong");
    shift_zero_a: assert property (acc_sh |=> status_q[FLAG_Z] == (rd_result_q == DATA_ZERO))
        else $error("zero flag wrong");
    t_load_a: assert property (acc_tld |=>
        rd_result_q[$past(op_bit)] == $past(status_q[FLAG_T]) && rd_wr_q)
        else $error("transfer load wrong");
    freeze_hold_a: assert property (!clk_en |=>
        $stable(status_q) && $stable(rd_result_q) && $stable(done_q) && $stable(io_wr_q))
        else $error("state moved while clock enable low");

    io_clr_c: cover property (acc_io ##2 io_wr_q);
    rol_c: cover property (accept && op_code == BSF_OP_ROL && status_q[FLAG_C]);
    fset_i_c: cover property (acc_fset && op_flag_sel == FLAG_I);
    tload_c: cover property (acc_tld && status_q[FLAG_T]);
    io_stall_c: cover property (!clk_en && state_q == BSF_ST_IO_WR);

endmodule

/* verif/bsf_io_model.sv */
`timescale 1ns/1ns
module bsf_io_model
    import bsf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic io_rd_q,
    input wire logic io_wr_q,
    input wire logic [IO_ADDR_W-1:0] io_addr_q,
    input wire logic [7:0] io_wdata_q,
    output logic [7:0] io_data
);
    // ----------------------------------------------------------------
    // I/O locations seen by the core
    // ----------------------------------------------------------------
    logic [7:0] mem [0:31];
    logic [7:0] last_q;

    // Preload every location with a distinct pattern
    initial
    begin
        for (int i = 0; i < 32; i++)
            mem[i] = 8'(i * 37) ^ 8'h5a;
        last_q = 8'h00;
    end

    // Read data only while the read strobe is up, else a changing value
    assign io_data = io_rd_q ? mem[io_addr_q] : ~last_q;

    // Write back and remember the last driven value
    always @(posedge clk_sys)
    begin
        if (io_wr_q)
            mem[io_addr_q] <= io_wdata_q;
        last_q <= io_data;
    end
endmodule

/* verif/bit_shift_flag_ops_tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end end
module bit_shift_flag_ops_tb_top
    import bsf_pkg::*;
();
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic stall = 1'b0;
    logic op_valid = 1'b0;
    bsf_op_t op_code = BSF_OP_NONE;
    logic [2:0] op_bit = 3'h0;
    logic [2:0] op_flag_sel = 3'h0;
    logic [4:0] op_io_addr = 5'h00;
    logic [7:0] rd_data = 8'h00;
    logic [7:0] io_data, rd_result_q, io_wdata_q, status_q, st;
    logic rd_wr_q, io_rd_q, io_wr_q, busy_q, done_q;
    logic [4:0] io_addr_q;
    int mismatches = 0;
    int comparisons = 0;

    always #5 clk_sys = ~clk_sys;

    bsf_core uut (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .op_valid(op_valid), .op_code(op_code),
        .op_bit(op_bit), .op_flag_sel(op_flag_sel), .op_io_addr(op_io_addr), .rd_data(rd_data),
        .io_data(io_data), .rd_result_q(rd_result_q), .rd_wr_q(rd_wr_q), .io_rd_q(io_rd_q),
        .io_wr_q(io_wr_q), .io_addr_q(io_addr_q), .io_wdata_q(io_wdata_q), .status_q(status_q),
        .busy_q(busy_q), .done_q(done_q));

    bsf_io_model io (.clk_sys(clk_sys), .io_rd_q(io_rd_q), .io_wr_q(io_wr_q), .io_addr_q(io_addr_q),
        .io_wdata_q(io_wdata_q), .io_data(io_data));

    // ----------------------------------------------------------------
    // Reference: result in the upper byte, flags in the lower byte
    // ----------------------------------------------------------------
    function automatic logic [15:0] ref_op(bsf_op_t op, logic [7:0] d, logic [7:0] s, logic [2:0] b);
        logic [7:0] r;
        logic c;
        r = d;
        c = s[FLAG_C];
        case (op)
            BSF_OP_LSL: {c, r} = {d, 1'b0};
            BSF_OP_LSR: {r, c} = {1'b0, d};
            BSF_OP_ROL: {c, r} = {d, s[FLAG_C]};
            BSF_OP_ROR: {r, c} = {s[FLAG_C], d};
            BSF_OP_ASR: {r, c} = {d[7], d};
            BSF_OP_SWAP: r = {d[3:0], d[7:4]};
            BSF_OP_FSET: s[b] = 1'b1;
            BSF_OP_FCLR: s[b] = 1'b0;
            BSF_OP_TSTORE: s[FLAG_T] = d[b];
            BSF_OP_TLOAD: r[b] = s[FLAG_T];
            default: r = d;
        endcase
        if (op inside {BSF_OP_LSL, BSF_OP_LSR, BSF_OP_ROL, BSF_OP_ROR, BSF_OP_ASR})
            s = {s[7:4], r[7] ^ c, r[7], r == 8'h00, c};
        return {r, s};
    endfunction

    // ----------------------------------------------------------------
    // One request, wait for completion, compare
    // ----------------------------------------------------------------
    task automatic run_op(input bsf_op_t op, input logic [7:0] d, input logic [2:0] b, input logic [4:0] a);
        logic [15:0] e;
        logic [7:0] m;
        logic wr;
        int n;
        e = ref_op(op, d, st, b);
        wr = op inside {BSF_OP_LSL, BSF_OP_LSR, BSF_OP_ROL, BSF_OP_ROR, BSF_OP_ASR, BSF_OP_SWAP, BSF_OP_TLOAD};
        n = 0;
        @(posedge clk_sys);
        op_valid <= 1'b1;
        clk_en <= 1'b1;
        op_code <= op;
        rd_data <= d;
        op_bit <= b;
        op_flag_sel <= b;
        op_io_addr <= a;
        @(posedge clk_sys);
        op_valid <= 1'b0;
        clk_en <= !stall;
        #1;
        // Earlier write-backs have landed; this read happens one edge later
        m = io.mem[a] & ~(8'h01 << b);
        `CHK("io_rd", op == BSF_OP_IO_CLR, io_rd_q)
        `CHK("busy", op == BSF_OP_IO_CLR, busy_q)
        while (done_q !== 1'b1 && n < 4)
        begin
            @(posedge clk_sys);
            clk_en <= 1'b1;
            #1;
            n++;
        end
        if (op == BSF_OP_IO_CLR)
        begin
            `CHK("io_cycles", 1 + int'(stall), n)
            `CHK("busy_end", 1'b0, busy_q)
            `CHK("io_wdata", m, io_wdata_q)
            `CHK("io_wr", 1'b1, io_wr_q)
            `CHK("io_addr", a, io_addr_q)
        end
        else
        begin
            `CHK("cycles", 0, n)
            `CHK("rd_wr", wr, rd_wr_q)
        end
        if (wr)
            `CHK("result", e[15:8], rd_result_q)
        `CHK("status", e[7:0], status_q)
        st = e[7:0];
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence: corners first, then random operations
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h4f02));
        st = 8'h00;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        `CHK("status_rst", STATUS_RST, status_q)
        for (int f = 0; f < 8; f++)
        begin
            run_op(BSF_OP_FSET, 8'($urandom), 3'(f), 5'h00);
            run_op(BSF_OP_FCLR, 8'($urandom), 3'(f), 5'h00);
            run_op(BSF_OP_FSET, 8'($urandom), 3'(f), 5'h00);
        end
        for (int k = 2; k < 8; k++)
        begin
            run_op(bsf_op_t'(k), 8'h80, 3'h0, 5'h00);
            run_op(bsf_op_t'(k), 8'h01, 3'h0, 5'h00);
            run_op(bsf_op_t'(k), 8'h00, 3'h0, 5'h00);
        end
        // Clock enable dropped for one edge after acceptance
        stall = 1'b1;
        run_op(BSF_OP_IO_CLR, 8'h00, 3'h7, 5'h1f);
        run_op(BSF_OP_LSL, 8'h81, 3'h0, 5'h00);
        repeat (300)
        begin
            stall = ($urandom_range(3) == 0);
            run_op(bsf_op_t'(1 + $urandom_range(10)), 8'($urandom), 3'($urandom), 5'($urandom));
        end
        close_out();
    end

    // Watchdog cuts a hang short
    initial
    begin
        #50000;
        mismatches++;
        close_out();
    end
endmodule
